// ### src/adc_clk_div.sv
// Sample tick generator with optional divide by two
`timescale 1ns/1ps
`default_nettype none
module adc_clk_div (
  input  wire logic clock_in,          // Core clock
  input  wire logic arst_n_in,         // Async reset, active low
  input  wire logic hold_in,           // Stop and realign divider
  input  wire logic clock_halve_n_in,  // Low divides by two
  output logic      sample_tick_out    // One-cycle sample strobe
);
  logic phase_r;                       // Divider phase

  // Phase flips each edge; held at zero so the first tick after hold is aligned
  always_ff @(posedge clock_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      phase_r <= 1'b0;
    end else if (hold_in) begin
      phase_r <= 1'b0;
    end else begin
      phase_r <= ~phase_r;
    end
  end

  // Undivided mode ticks every cycle outside hold
  assign sample_tick_out = ~hold_in & (clock_halve_n_in | phase_r);
endmodule
`default_nettype wire

// ### src/adc_out_ctrl.sv
// Converter digital output control: straps, calibration, pipeline and APB
// Function
// - Reference-select low internal, high external
// - Clock-halve select low divides clock by two
// - Reset input active low holds conversion logic
// - Format low two's complement, high offset binary
// - Eight-bit word, bit 0 LSB, bit 7 MSB
// - Output word 28 sample clocks after start
// - Calibration begins on rising edge of reset
// - Over-range forced high until calibration completes
// - Output clock low during reset, resumes after
//
// Chosen here: the APB interface to the registers and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
module adc_out_ctrl
  import adc_pkg::*;
#(
  parameter int unsigned LATENCY  = adc_pkg::LATENCY_CYC, // Sample ticks of latency
  parameter int unsigned CAL_CYC  = adc_pkg::CAL_CYCLES   // Calibration length, cycles
) (
  input  wire logic                      clock_in,           // Core clock, 20 MHz
  input  wire logic                      arst_n_in,          // Async reset, active low
  input  wire logic                      cal_reset_n_in,     // Device reset pin, active low
  input  wire logic                      ref_source_select_in, // 0 internal, 1 external
  input  wire logic                      clock_halve_n_in,   // 0 halves sample clock
  input  wire logic                      twos_comp_select_n_in, // 0 two's complement
  input  wire logic [adc_pkg::DATA_W-1:0] raw_code_in,       // Offset-binary code from core
  input  wire logic                      raw_over_in,        // Core over-range indication
  output logic                           ref_external_out,   // Use external reference
  output logic      [adc_pkg::DATA_W-1:0] sample_data_out,   // Parallel word
  output logic                           over_range_out,     // Over-range flag
  output logic                           sample_clock_out,   // Output clock
  input  wire logic                      psel,               // APB select
  input  wire logic                      penable,            // APB access phase
  input  wire logic                      pwrite,             // APB write
  input  wire logic [7:0]                paddr,              // APB byte address
  input  wire logic [31:0]               pwdata,             // APB write data
  output logic      [31:0]               prdata,             // APB read data
  output logic                           pready,             // APB ready
  output logic                           pslverr,            // APB error
  output logic                           irq_out             // Level interrupt
);
  import adc_pkg::*;

  localparam int unsigned CW = $clog2(CAL_CYC + 1); // Calibration counter width

  initial begin
    if (LATENCY < 3) $error("adc_out_ctrl: latency too small");
    if (CAL_CYC < 1) $error("adc_out_ctrl: calibration length zero");
  end

  // Address decode shared by read and write paths
  function automatic logic known_addr(input logic [7:0] a);
    known_addr = (a == OFS_CTRL) || (a == OFS_STATUS) || (a == OFS_IRQ_STAT) ||
                 (a == OFS_IRQ_MASK) || (a == OFS_LAST);
  endfunction

  adc_state_t    state_r;               // Control state
  adc_state_t    state_nxt;             // Next control state
  logic [CW-1:0] cal_cnt_r;             // Calibration cycles left
  logic          rst_pin_r;             // Reset pin seen last cycle
  logic          soft_recal;            // Software recalibration pulse
  logic          hold;                  // Conversion held in reset
  logic          tick;                  // Sample strobe
  logic [DATA_W:0] delayed;             // Word and flag leaving memory
  logic [DATA_W-1:0] data_r;            // Output word
  logic          over_r;                // Output over-range
  logic          oclk_r;                // Output clock
  logic          ref_r;                 // Reference choice
  logic [1:0]    irq_stat_r;            // Sticky events
  logic [1:0]    irq_mask_r;            // Interrupt enables
  logic [1:0]    irq_set;               // Event pulses this cycle
  logic          cal_done;              // Calibration finishes this cycle
  logic          wr_acc;                // Write access phase
  logic          setup;                 // Setup phase
  logic [31:0]   rd_val;                // Read mux value
  logic [31:0]   prdata_r;              // Registered read data
  logic          pslverr_r;             // Registered error

  // Conversion logic held while the pin is low
  assign hold = (state_r == ADC_ST_HOLD);

  // Software writes one to start a recalibration
  assign wr_acc     = psel & penable & pwrite;
  assign setup      = psel & ~penable;
  assign soft_recal = wr_acc && (paddr == OFS_CTRL) && pwdata[CTRL_RECAL_BIT];

  // Previous reset pin level for rising-edge detection
  always_ff @(posedge clock_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      rst_pin_r <= 1'b0;
    end else begin
      rst_pin_r <= cal_reset_n_in;
    end
  end

  // State transitions
  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      ADC_ST_HOLD: begin
        if (cal_reset_n_in && !rst_pin_r) begin
          state_nxt = ADC_ST_CAL;
        end
      end
      ADC_ST_CAL: begin
        if (cal_cnt_r == CW'(1)) begin
          state_nxt = ADC_ST_RUN;
        end
      end
      ADC_ST_RUN: begin
        if (soft_recal) begin
          state_nxt = ADC_ST_CAL;       // Soft path skips the pin
        end
      end
      default: state_nxt = ADC_ST_HOLD; // Illegal code recovers
    endcase
    if (!cal_reset_n_in) begin
      state_nxt = ADC_ST_HOLD;
    end
  end

  assign cal_done = (state_r == ADC_ST_CAL) && (state_nxt == ADC_ST_RUN);

  // State register; powers up holding so a calibration follows the first release
  always_ff @(posedge clock_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      state_r <= ADC_ST_HOLD;
    end else begin
      state_r <= state_nxt;
    end
  end

  // Calibration counter, loaded when calibration starts
  always_ff @(posedge clock_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      cal_cnt_r <= '0;
    end else if (state_nxt == ADC_ST_CAL && state_r != ADC_ST_CAL) begin
      cal_cnt_r <= CW'(CAL_CYC);
    end else if (state_r == ADC_ST_CAL) begin
      cal_cnt_r <= cal_cnt_r - CW'(1);
    end
  end

  // Sample clock from core clock
  adc_clk_div u_div (
    .clock_in         (clock_in),
    .arst_n_in        (arst_n_in),
    .hold_in          (hold),
    .clock_halve_n_in (clock_halve_n_in),
    .sample_tick_out  (tick)
  );

  // Pipeline delay; memory plus output register give the full latency
  adc_pipe_mem #(
    .WIDTH (DATA_W + 1),
    .DEPTH (LATENCY - 1)
  ) u_mem (
    .clock_in  (clock_in),
    .arst_n_in (arst_n_in),
    .adv_in    (tick),
    .wr_in     ({raw_over_in, raw_code_in}),
    .rd_out    (delayed)
  );

  // Output word, coded at delivery; MSB flip gives two's complement
  always_ff @(posedge clock_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      data_r <= DATA_RST;
    end else if (tick) begin
      data_r <= {delayed[DATA_W-1] ^ ~twos_comp_select_n_in,
                 delayed[DATA_W-2:0]};
    end
  end

  // Over-range forced during reset and calibration
  always_ff @(posedge clock_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      over_r <= 1'b1;
    end else if (!cal_reset_n_in || state_nxt != ADC_ST_RUN) begin
      over_r <= 1'b1;
    end else if (tick) begin
      over_r <= delayed[DATA_W];
    end
  end

  // Output clock toggles with each new word; either edge marks fresh data
  always_ff @(posedge clock_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      oclk_r <= 1'b0;
    end else if (!cal_reset_n_in || hold) begin
      oclk_r <= 1'b0;
    end else if (tick) begin
      oclk_r <= ~oclk_r;
    end
  end

  // Reference choice follows its select pin
  always_ff @(posedge clock_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      ref_r <= 1'b0;
    end else begin
      ref_r <= ref_source_select_in;
    end
  end

  assign sample_data_out  = data_r;
  assign over_range_out   = over_r;
  assign sample_clock_out = oclk_r;
  assign ref_external_out = ref_r;

  // Events: over-range only counts once calibration is over
  assign irq_set[IRQ_CALDONE] = cal_done;
  assign irq_set[IRQ_OVR]     = tick && (state_r == ADC_ST_RUN) && delayed[DATA_W];

  // Sticky status; a new event beats a same-cycle clear
  always_ff @(posedge clock_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      irq_stat_r <= '0;
    end else if (wr_acc && paddr == OFS_IRQ_STAT) begin
      irq_stat_r <= (irq_stat_r & ~pwdata[1:0]) | irq_set;
    end else begin
      irq_stat_r <= irq_stat_r | irq_set;
    end
  end

  // Mask register
  always_ff @(posedge clock_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      irq_mask_r <= IRQ_MASK_RST;
    end else if (wr_acc && paddr == OFS_IRQ_MASK) begin
      irq_mask_r <= pwdata[1:0];
    end
  end

  assign irq_out = |(irq_stat_r & irq_mask_r);

  // Read mux
  always_comb begin
    rd_val = '0;
    unique case (paddr)
      OFS_STATUS: begin
        rd_val[ST_CAL_BIT]   = (state_r == ADC_ST_CAL);
        rd_val[ST_RST_BIT]   = hold;
        rd_val[ST_REF_BIT]   = ref_r;
        rd_val[ST_HALVE_BIT] = clock_halve_n_in;
        rd_val[ST_FMT_BIT]   = twos_comp_select_n_in;
      end
      OFS_IRQ_STAT: rd_val[1:0] = irq_stat_r;
      OFS_IRQ_MASK: rd_val[1:0] = irq_mask_r;
      OFS_LAST:     rd_val[LAST_OVR_BIT:0] = {over_r, data_r};
      default:      rd_val = '0; // Control reads zero, unmapped too
    endcase
  end

  // Read data and error captured in setup, stable through access
  always_ff @(posedge clock_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      prdata_r  <= '0;
      pslverr_r <= 1'b0;
    end else if (setup) begin
      prdata_r  <= pwrite ? 32'h0000_0000 : rd_val;
      pslverr_r <= ~known_addr(paddr);
    end
  end

  // Zero-wait slave: every access phase completes at once
  assign pready  = 1'b1;
  assign prdata  = prdata_r;
  assign pslverr = pslverr_r & psel & penable;
endmodule
`default_nettype wire

// ### src/adc_pipe_mem.sv
// Ring-buffer delay memory with registered read data
`timescale 1ns/1ps
`default_nettype none
module adc_pipe_mem #(
  parameter int unsigned WIDTH = 9,    // Word width
  parameter int unsigned DEPTH = 27    // Ticks of delay to read register
) (
  input  wire logic             clock_in,  // Core clock
  input  wire logic             arst_n_in, // Async reset, active low
  input  wire logic             adv_in,    // Advance one sample
  input  wire logic [WIDTH-1:0] wr_in,     // Word entering
  output logic      [WIDTH-1:0] rd_out     // Word leaving, registered
);
  localparam int unsigned PW = (DEPTH > 1) ? $clog2(DEPTH) : 1; // Pointer width

  initial begin
    if (DEPTH < 2 || WIDTH < 1) $error("adc_pipe_mem: bad size");
  end

  logic [WIDTH-1:0] mem_r [DEPTH];     // Storage, not reset
  logic [PW-1:0]    ptr_r;             // Oldest entry index

  // Read old word and overwrite it in the same tick
  always_ff @(posedge clock_in) begin
    if (adv_in) begin
      mem_r[ptr_r] <= wr_in;
    end
  end

  // Read register and pointer
  always_ff @(posedge clock_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      rd_out <= '0;
      ptr_r  <= '0;
    end else if (adv_in) begin
      rd_out <= mem_r[ptr_r];
      ptr_r  <= (ptr_r == PW'(DEPTH - 1)) ? '0 : ptr_r + PW'(1);
    end
  end
endmodule
`default_nettype wire

// ### src/adc_pkg.sv
// Shared constants for the converter output control block
package adc_pkg;
  // Clock and timing
  localparam int unsigned CLK_HZ      = 20_000_000;     // Core clock rate
  localparam int unsigned LATENCY_CYC = 28;             // Sample ticks start to output
  localparam int unsigned CAL_TIME_MS = 240;            // Nominal calibration time
  localparam int unsigned CAL_CYCLES  = (CAL_TIME_MS * (CLK_HZ / 1000)); // 4.8M cycles
  localparam int unsigned DATA_W      = 8;              // Sample word width

  // Register byte offsets
  localparam logic [7:0] OFS_CTRL     = 8'h00;          // Control, write-only pulses
  localparam logic [7:0] OFS_STATUS   = 8'h04;          // Live state
  localparam logic [7:0] OFS_IRQ_STAT = 8'h08;          // Sticky events, write one to clear
  localparam logic [7:0] OFS_IRQ_MASK = 8'h0C;          // Interrupt enables
  localparam logic [7:0] OFS_LAST     = 8'h10;          // Last delivered sample

  // Field positions
  localparam int unsigned CTRL_RECAL_BIT = 0;           // Start recalibration
  localparam int unsigned ST_CAL_BIT     = 0;           // Calibration running
  localparam int unsigned ST_RST_BIT     = 1;           // Reset pin held low
  localparam int unsigned ST_REF_BIT     = 2;           // External reference chosen
  localparam int unsigned ST_HALVE_BIT   = 3;           // Clock halve select pin level
  localparam int unsigned ST_FMT_BIT     = 4;           // Format select pin level
  localparam int unsigned IRQ_CALDONE    = 0;           // Calibration finished
  localparam int unsigned IRQ_OVR        = 1;           // Over-range seen
  localparam int unsigned LAST_OVR_BIT   = 8;           // Over-range flag of last sample

  // Reset values
  localparam logic [1:0] IRQ_MASK_RST = 2'h0;           // All interrupts masked
  localparam logic [7:0] DATA_RST     = 8'h00;          // Output word after reset

  // Control states
  typedef enum logic [2:0] {
    ADC_ST_HOLD = 3'b001,                               // Reset pin low
    ADC_ST_CAL  = 3'b010,                               // Calibrating
    ADC_ST_RUN  = 3'b100                                // Normal conversion
  } adc_state_t;
endpackage

// ### verification/adc_capture_model.sv
// Board capture logic taking words on output clock changes
`timescale 1ns/1ps
`default_nettype none
module adc_capture_model (
  input  wire logic       clock_in,        // Core clock
  input  wire logic       arst_n_in,       // Async reset
  input  wire logic       sample_clock_in, // Output clock of block
  input  wire logic [7:0] data_in,         // Parallel word
  output logic      [7:0] word_out,        // Last captured word
  output logic      [15:0] edges_out       // Clock changes seen
);
  logic prev_r; // Output clock one cycle ago
  // Capture on either clock change, one cycle late
  always_ff @(posedge clock_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      prev_r    <= 1'b0;
      word_out  <= 8'h00;
      edges_out <= 16'h0000;
    end else begin
      prev_r <= sample_clock_in;
      if (sample_clock_in != prev_r) begin
        word_out  <= data_in;
        edges_out <= edges_out + 16'h0001;
      end
    end
  end
endmodule
`default_nettype wire

// ### verification/adc_out_ctrl_chk.sv
// Concurrent checks on the converter output control ports
`timescale 1ns/1ps
`default_nettype none
module adc_out_ctrl_chk
  import adc_pkg::*;
#(
  parameter int unsigned LATENCY = adc_pkg::LATENCY_CYC, // Sample ticks of latency
  parameter int unsigned CAL_CYC = adc_pkg::CAL_CYCLES   // Calibration length
) (
  input wire logic                       clock_in,              // Core clock
  input wire logic                       arst_n_in,             // Async reset
  input wire logic                       cal_reset_n_in,        // Device reset pin
  input wire logic                       ref_source_select_in,  // Reference pin
  input wire logic                       clock_halve_n_in,      // Halve pin
  input wire logic                       twos_comp_select_n_in, // Format pin
  input wire logic                       ref_external_out,      // Reference choice
  input wire logic [adc_pkg::DATA_W-1:0] sample_data_out,       // Output word
  input wire logic                       over_range_out,        // Over-range flag
  input wire logic                       sample_clock_out       // Output clock
);
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (!arst_n_in);
  // Pin low two samples running
  sequence s_held; !cal_reset_n_in [*2]; endsequence
  // Settled undivided and divided running
  sequence s_undiv; (cal_reset_n_in && clock_halve_n_in) [*4]; endsequence
  sequence s_div; (cal_reset_n_in && !clock_halve_n_in) [*4]; endsequence
  property p_ref;
    $changed(ref_source_select_in) |=> ref_external_out == $past(ref_source_select_in);
  endproperty
  a_ref: assert property (p_ref) else $error("reference choice wrong");
  property p_clk_hold; s_held |=> !sample_clock_out; endproperty
  a_clk_hold: assert property (p_clk_hold) else $error("clock runs in reset");
  property p_or_hold; s_held |=> over_range_out; endproperty
  a_or_hold: assert property (p_or_hold) else $error("flag low in reset");
  property p_or_cal; $rose(cal_reset_n_in) |-> over_range_out [*8]; endproperty
  a_or_cal: assert property (p_or_cal) else $error("flag low in calibration");
  property p_resume;
    $rose(cal_reset_n_in) && clock_halve_n_in |-> ##[1:3] $changed(sample_clock_out);
  endproperty
  a_resume: assert property (p_resume) else $error("clock did not resume");
  property p_undiv; s_undiv |=> $changed(sample_clock_out); endproperty
  a_undiv: assert property (p_undiv) else $error("undivided tick missed");
  property p_div_a; s_div ##0 $changed(sample_clock_out) |=> $stable(sample_clock_out); endproperty
  a_div_a: assert property (p_div_a) else $error("divided tick too soon");
  property p_div_b; s_div ##0 $stable(sample_clock_out) |=> $changed(sample_clock_out); endproperty
  a_div_b: assert property (p_div_b) else $error("divided tick missed");
  // Data moves only with the output clock
  property p_align;
    $changed(sample_data_out) && cal_reset_n_in && $past(cal_reset_n_in) &&
    $stable(twos_comp_select_n_in) &&
    $past(twos_comp_select_n_in) == $past(twos_comp_select_n_in, 2) |->
    $changed(sample_clock_out);
  endproperty
  a_align: assert property (p_align) else $error("data not aligned to clock");
endmodule
bind adc_out_ctrl adc_out_ctrl_chk #(.LATENCY(LATENCY), .CAL_CYC(CAL_CYC)) i_chk (
  .clock_in(clock_in), .arst_n_in(arst_n_in), .cal_reset_n_in(cal_reset_n_in),
  .ref_source_select_in(ref_source_select_in), .clock_halve_n_in(clock_halve_n_in),
  .twos_comp_select_n_in(twos_comp_select_n_in), .ref_external_out(ref_external_out),
  .sample_data_out(sample_data_out), .over_range_out(over_range_out),
  .sample_clock_out(sample_clock_out));
`default_nettype wire

// ### verification/tb_adc_out_ctrl.sv
// Self-checking testbench for the converter output control block
`timescale 1ns/1ps
`default_nettype none
module tb_adc_out_ctrl;
  import adc_pkg::*;
  localparam int unsigned CAL_SIM = 20; // Short calibration
  logic        clock_in = 1'b0;  // Core clock
  logic        arst_n_in = 1'b0; // Async reset
  logic        pin_n = 1'b0;     // Device reset pin
  logic        ref_sel = 1'b0;   // Reference select
  logic        halve_n = 1'b1;   // Undivided at start
  logic        fmt_n = 1'b1;     // Offset binary at start
  logic [7:0]  raw_code = 8'h00; // Core code
  logic        raw_over = 1'b0;  // Core over-range
  logic        psel = 1'b0;      // APB select
  logic        penable = 1'b0;   // APB enable
  logic        pwrite = 1'b0;    // APB direction
  logic [7:0]  paddr = 8'h00;    // APB address
  logic [31:0] pwdata = 32'h0;   // APB write data
  logic [31:0] prdata, rd_v;     // Read data
  logic        pready, pslverr, er_v, irq, ref_ext, over, sclk;
  logic [7:0]  data, cap_word;   // Word and captured word
  logic [15:0] cap_edges;        // Captured clock changes
  int          errors = 0;
  int          checks = 0;
  always #25 clock_in = ~clock_in;
  adc_out_ctrl #(.CAL_CYC(CAL_SIM)) i_dut (
    .clock_in(clock_in), .arst_n_in(arst_n_in), .cal_reset_n_in(pin_n),
    .ref_source_select_in(ref_sel), .clock_halve_n_in(halve_n),
    .twos_comp_select_n_in(fmt_n), .raw_code_in(raw_code), .raw_over_in(raw_over),
    .ref_external_out(ref_ext), .sample_data_out(data), .over_range_out(over),
    .sample_clock_out(sclk), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .irq_out(irq));
  adc_capture_model i_cap (
    .clock_in(clock_in), .arst_n_in(arst_n_in), .sample_clock_in(sclk),
    .data_in(data), .word_out(cap_word), .edges_out(cap_edges));
  task automatic final_report();
    $display("checks=%0d errors=%0d", checks, errors);
    if (errors == 0 && checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      errors++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clock_in);
    #1;
  endtask
  // One APB transfer, waits on pready under a bound
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge clock_in);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock_in);
    penable <= 1'b1;
    @(posedge clock_in);
    while (pready !== 1'b1 && k < 20) begin
      k++;
      @(posedge clock_in);
    end
    if (k == 20) errors++;
    rd_v = prdata;
    er_v = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic t_calib();
    cyc(3);
    check(over, 1'b1);
    check(sclk, 1'b0);
    apb(1'b0, OFS_STATUS, 32'h0);
    check(rd_v[ST_RST_BIT], 1'b1);
    apb(1'b0, OFS_IRQ_MASK, 32'h0);
    check(rd_v, {30'h0, IRQ_MASK_RST});
    @(posedge clock_in);
    pin_n <= 1'b1;
    cyc(4);
    check(over, 1'b1);
    apb(1'b0, OFS_STATUS, 32'h0);
    check(rd_v[ST_CAL_BIT], 1'b1);
    cyc(CAL_SIM + 40);
    check(over, 1'b0);
    apb(1'b0, OFS_IRQ_STAT, 32'h0);
    check(rd_v[IRQ_CALDONE], 1'b1);
    check(irq, 1'b0);
    $display("test calib done");
  endtask
  task automatic t_irq();
    apb(1'b1, OFS_IRQ_MASK, 32'h1);
    cyc(2);
    check(irq, 1'b1);
    apb(1'b1, OFS_IRQ_STAT, 32'h1);
    cyc(2);
    check(irq, 1'b0);
    apb(1'b0, 8'h40, 32'h0);
    check(er_v, 1'b1);
    check(rd_v, 32'h0);
    $display("test irq done");
  endtask
  // Software recalibration, then a pin pulse mid-run
  task automatic t_recal();
    apb(1'b1, OFS_CTRL, 32'h1);
    cyc(1);
    check(over, 1'b1);
    apb(1'b0, OFS_STATUS, 32'h0);
    check(rd_v[ST_CAL_BIT], 1'b1);
    cyc(CAL_SIM + 10);
    check(over, 1'b0);
    @(posedge clock_in);
    pin_n <= 1'b0;
    cyc(2);
    check(sclk, 1'b0);
    check(over, 1'b1);
    apb(1'b0, OFS_STATUS, 32'h0);
    check(rd_v[ST_RST_BIT], 1'b1);
    @(posedge clock_in);
    pin_n <= 1'b1;
    cyc(4);
    check(over, 1'b1);
    cyc(CAL_SIM + 10);
    check(over, 1'b0);
    check(irq, 1'b1);
    $display("test recal done");
  endtask
  task automatic t_ref();
    @(posedge clock_in);
    ref_sel <= 1'b1;
    cyc(2);
    check(ref_ext, 1'b1);
    apb(1'b0, OFS_STATUS, 32'h0);
    check(rd_v[ST_REF_BIT], 1'b1);
    @(posedge clock_in);
    ref_sel <= 1'b0;
    cyc(2);
    check(ref_ext, 1'b0);
    $display("test ref done");
  endtask
  // Counting stream, word due 28 ticks after it is taken
  task automatic t_stream(input logic f);
    logic [7:0] v, prev_d;
    for (int j = 0; j < 50; j++) begin
      @(posedge clock_in);
      fmt_n <= f;
      raw_code <= 8'(j);
      raw_over <= j[0];
      #1;
      v = 8'(j - 29);
      if (j >= 37) begin
        check(data, {v[7] ^ ~f, v[6:0]});
        check(over, v[0]);
        check(cap_word, prev_d);
      end
      prev_d = data;
    end
    $display("test stream done");
  endtask
  task automatic t_div(input logic h, input int n);
    int n0;
    @(posedge clock_in);
    halve_n <= h;
    cyc(6);
    n0 = cap_edges;
    cyc(40);
    check(32'(cap_edges - n0), 32'(n));
    $display("test divide done");
  endtask
  initial begin
    repeat (10) @(posedge clock_in);
    arst_n_in <= 1'b1;
    t_calib();
    t_irq();
    t_recal();
    t_ref();
    t_stream(1'b1);
    t_stream(1'b0);
    t_div(1'b0, 20);
    t_div(1'b1, 40);
    final_report();
  end
  // Watchdog far beyond the expected run
  initial begin
    #(5000 * 50);
    errors++;
    final_report();
  end
endmodule
`default_nettype wire
